// ===== pic_consts.svh
/*
  Constants of the pulse interval capture block: register offsets, field
  positions, reset values and timing figures. Assumes inclusion by bare name.
*/
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_IRQ_STAT 12'h008
`define OFF_IRQ_MASK 12'h00c
`define OFF_CAPTURE 12'h010
`define OFF_BUFFER 12'h020
`define BUF_PAGE 7'h01

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define CTRL_START 0
`define CTRL_EXT 1
`define CTRL_PSC_LO 2
`define CTRL_PSC_HI 5
`define IRQ_CAPTURE 0
`define IRQ_COMPLETE 1
`define IRQ_W 2

// ----------------------------------------------------------------------
// Sizes, reset values and timing.
// ----------------------------------------------------------------------
`define CNT_MAX 16'hffff
`define CNT_ZERO 16'h0000
`define RESULT_COUNT 4'h8
`define LAST_SLOT 3'h7
`define SYS_CLK_HZ 125000000
`define COUNT_CLK_HZ 6000000
`define BASE_DIV ((`SYS_CLK_HZ + `COUNT_CLK_HZ / 2) / `COUNT_CLK_HZ)
`define PSC_RESET 4'h0

`endif

// ===== pic_pkg.sv
/*
  Types shared by the pulse interval capture block. Assumes nothing.
*/
package pic_pkg;
  // Measurement sequence: idle, waiting for the discarded first edge, measuring.
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_MEASURE} meas_state_e;
endpackage : pic_pkg

// ===== pic_pulse_source.sv
/*
  Partner model of the external pulse source that drives the capture pin.
  Assumes the caller enters pulse() just after a rising edge of sys_clk.
*/
`timescale 1ns/100ps
module pic_pulse_source
  import pic_pkg::*;
(
  // Clock.
  input wire logic sys_clk,
  // Pulse pin toward the block.
  output logic pulseInputPin
);
  // ----------------------------------------------------------------------
  // Pin driver.
  // ----------------------------------------------------------------------
  // The pin idles low and is always driven, so it never floats.
  initial pulseInputPin = 1'b0;

  // One period: a rise, a high half and a low half, gap clocks rise to rise.
  // The falling edge in the middle must never be taken as a valid edge.
  task automatic pulse(input int gap);
    int g;
    // Edges closer than the block's handling time would be lost.
    g = (gap < 31) ? 31 : gap;
    pulseInputPin <= 1'b1;
    repeat (g / 2) @(posedge sys_clk);
    pulseInputPin <= 1'b0;
    // Callers keep gap below one counter wrap, so one overflow at most.
    repeat (g - g / 2) @(posedge sys_clk);
  endtask : pulse
endmodule : pic_pulse_source

// ===== pic_sync.sv
/*
  Two flip-flop synchroniser for asynchronous levels.
  Assumes the output is read only by logic on clk.
*/
`timescale 1ns/100ps
module pic_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Level in and synchronised level out.
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff; // First stage; read only by the second stage.

  // Two stages; only dout may be seen by other logic.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      dout <= '0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule : pic_sync

// ===== pulse_interval_capture.sv
/*
  Pulse interval capture channel with APB register access and an 8-entry
  result buffer. Assumes an APB master on sys_clk and an asynchronous pulse
  source on pulseInputPin.

*/
`timescale 1ns/100ps
`include "pic_consts.svh"
module pulse_interval_capture
  import pic_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pulse pin and events.
  input wire logic pulseInputPin,
  output logic captureDoneEvent,
  output logic measurementComplete,
  output logic irq
);
  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  localparam int BASE_DIV = `BASE_DIV; // System clocks per count clock.
  meas_state_e state_ff; // Sequence state.
  logic pinSync; // Pin after two flip-flops.
  logic pinPrev_ff; // Pin one cycle earlier.
  logic rise; // Rising edge seen this cycle.
  logic [4:0] baseCnt_ff; // Divider to the reference count clock.
  logic baseTick; // One pulse per reference count clock.
  logic [14:0] pscCnt_ff; // Prescaler chain of base ticks.
  logic [14:0] pscMask; // Low prescaler bits that must all be set.
  logic cntEn; // One pulse per selected count clock.
  logic [15:0] intervalCounter_ff; // The interval counter, held while idle and cleared at each capture.
  logic overflowStatus_ff; // Counter wrapped since the last capture.
  logic extMode_ff; // Seventeen bit mode select.
  logic [3:0] countClockPrescaler_ff; // Prescaler select.
  logic [2:0] resultCount_ff; // Next slot, counted from the first store.
  logic complete_ff; // All eight results stored.
  logic [16:0] capturedCount_ff; // Most recent captured interval.
  logic [15:0] buffer_ff [16]; // Result store, as halfwords.
  logic [15:0] resultLo; // Halfword of count to store.
  logic storeEn; // A capture that is kept.
  logic startReq; // Software start.
  logic busWrite; // Write taken this cycle.
  logic [`IRQ_W-1:0] irqStat_ff; // Sticky event bits.
  logic [`IRQ_W-1:0] irqMask_ff; // Event enables.
  logic [`IRQ_W-1:0] irqSet; // Events this cycle.
  logic mapped; // Address decodes to a register.
  logic [31:0] nxt_prdata; // Read value to latch at setup.

  // ----------------------------------------------------------------------
  // Pin synchronisation and edge detection.
  // ----------------------------------------------------------------------
  pic_sync #(.W(1)) pinSyncInst (
    .clk(sys_clk),
    .rst(sys_rst),
    .din(pulseInputPin),
    .dout(pinSync)
  );

  // Edge history is taken after the synchroniser, never from its first stage.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinPrev_ff <= 1'b0;
    end else begin
      pinPrev_ff <= pinSync;
    end
  end

  // A falling edge is ignored by design.
  assign rise = pinSync && !pinPrev_ff;

  // ----------------------------------------------------------------------
  // Count clock: base divider and prescaler, as one-cycle enables.
  // ----------------------------------------------------------------------
  // The base rate is rounded to whole system clocks, so it is close to but
  // not exactly the reference count clock.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      baseCnt_ff <= 5'h00;
    end else if (baseTick) begin
      baseCnt_ff <= 5'h00;
    end else begin
      baseCnt_ff <= baseCnt_ff + 5'h01;
    end
  end

  assign baseTick = (baseCnt_ff == 5'(BASE_DIV - 1));

  // Each prescaler step halves the count clock and doubles the range.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pscCnt_ff <= 15'h0000;
    end else if (startReq) begin
      pscCnt_ff <= 15'h0000;
    end else if (baseTick) begin
      pscCnt_ff <= pscCnt_ff + 15'h0001;
    end
  end

  assign pscMask = 15'((16'h0001 << countClockPrescaler_ff) - 16'h0001);
  assign cntEn = baseTick && ((pscCnt_ff & pscMask) == pscMask);

  // ----------------------------------------------------------------------
  // Interval counter and overflow status.
  // ----------------------------------------------------------------------
  // A capture wins over a count step in the same cycle: the counter restarts.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      intervalCounter_ff <= `CNT_ZERO;
    end else if (startReq || (rise && state_ff != ST_IDLE)) begin
      intervalCounter_ff <= `CNT_ZERO;
    end else if (cntEn && state_ff != ST_IDLE) begin
      intervalCounter_ff <= intervalCounter_ff + 16'h0001;
    end
  end

  // Set on wrap; the capture that ends the interval clears it.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflowStatus_ff <= 1'b0;
    end else if (startReq || (rise && state_ff != ST_IDLE)) begin
      overflowStatus_ff <= 1'b0;
    end else if (cntEn && state_ff != ST_IDLE && intervalCounter_ff == `CNT_MAX) begin
      overflowStatus_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Sequence control.
  // ----------------------------------------------------------------------
  assign storeEn = rise && (state_ff == ST_MEASURE);

  // A start while busy restarts the whole measurement.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
    end else if (startReq) begin
      state_ff <= ST_ARMED;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          state_ff <= ST_IDLE;
        end
        ST_ARMED: begin
          // The first edge only opens the first interval.
          if (rise) begin
            state_ff <= ST_MEASURE;
          end
        end
        ST_MEASURE: begin
          if (storeEn && resultCount_ff == `LAST_SLOT) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Number of results already stored; also selects the slot.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resultCount_ff <= 3'h0;
      complete_ff <= 1'b0;
    end else if (startReq) begin
      resultCount_ff <= 3'h0;
      complete_ff <= 1'b0;
    end else if (storeEn) begin
      resultCount_ff <= resultCount_ff + 3'h1;
      complete_ff <= (resultCount_ff == `LAST_SLOT);
    end
  end

  // ----------------------------------------------------------------------
  // Capture and result store.
  // ----------------------------------------------------------------------
  // Default mode reports an overflowed interval as zero. Results below 6
  // cannot come from a legal edge spacing and are not to be trusted.
  assign resultLo = (!extMode_ff && overflowStatus_ff) ? `CNT_ZERO
                    : intervalCounter_ff;

  // Each capture, kept or not, updates the readable captured count.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      capturedCount_ff <= 17'h00000;
      captureDoneEvent <= 1'b0;
    end else begin
      captureDoneEvent <= rise && (state_ff != ST_IDLE);
      if (rise && state_ff != ST_IDLE) begin
        capturedCount_ff <= {extMode_ff && overflowStatus_ff, resultLo};
      end
    end
  end

  // Slots run from the top down; the low halfword sits at the low address.
  // Default mode: halfword 7-n. Extended: count at 14-2n, status at 15-2n.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        buffer_ff[i] <= 16'h0000;
      end
    end else if (storeEn) begin
      if (extMode_ff) begin
        buffer_ff[{~resultCount_ff, 1'b0}] <= resultLo;
        buffer_ff[{~resultCount_ff, 1'b1}] <= {15'h0000, overflowStatus_ff};
      end else begin
        buffer_ff[{1'b0, ~resultCount_ff}] <= resultLo;
      end
    end
  end

  assign measurementComplete = complete_ff;

  // ----------------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped addresses.
  // ----------------------------------------------------------------------
  assign pready = 1'b1;
  assign mapped = (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS)
                  || (paddr == `OFF_IRQ_STAT) || (paddr == `OFF_IRQ_MASK)
                  || (paddr == `OFF_CAPTURE)
                  || (paddr[11:5] == `BUF_PAGE && paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !mapped;
  assign busWrite = psel && penable && pwrite && mapped;
  assign startReq = busWrite && (paddr == `OFF_CTRL) && pwdata[`CTRL_START];

  // Mode and prescaler may be rewritten at any time; changes take effect
  // mid-interval, so software should set them before a start.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      extMode_ff <= 1'b0;
      countClockPrescaler_ff <= `PSC_RESET;
    end else if (busWrite && paddr == `OFF_CTRL) begin
      extMode_ff <= pwdata[`CTRL_EXT];
      countClockPrescaler_ff <= pwdata[`CTRL_PSC_HI:`CTRL_PSC_LO];
    end
  end

  assign irqSet = {complete_ff == 1'b0 && storeEn && resultCount_ff == `LAST_SLOT,
                   rise && state_ff != ST_IDLE};

  // Write one to clear; a new event in the same cycle wins.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat_ff <= '0;
      irqMask_ff <= '0;
    end else begin
      if (busWrite && paddr == `OFF_IRQ_STAT) begin
        irqStat_ff <= (irqStat_ff & ~pwdata[`IRQ_W-1:0]) | irqSet;
      end else begin
        irqStat_ff <= irqStat_ff | irqSet;
      end
      if (busWrite && paddr == `OFF_IRQ_MASK) begin
        irqMask_ff <= pwdata[`IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irqStat_ff & irqMask_ff);

  // Read mux; latched in the setup cycle so the access phase sees a flop.
  always_comb begin
    nxt_prdata = 32'h00000000;
    if (paddr[11:5] == `BUF_PAGE) begin
      nxt_prdata = {buffer_ff[{paddr[4:2], 1'b1}], buffer_ff[{paddr[4:2], 1'b0}]};
    end else begin
      unique case (paddr)
        `OFF_CTRL: begin
          nxt_prdata = {26'h0000000, countClockPrescaler_ff, extMode_ff, 1'b0};
        end
        `OFF_STATUS: begin
          nxt_prdata = {25'h0000000, resultCount_ff, 1'b0, overflowStatus_ff,
                        complete_ff, state_ff != ST_IDLE};
        end
        `OFF_IRQ_STAT: begin
          nxt_prdata = {30'h00000000, irqStat_ff};
        end
        `OFF_IRQ_MASK: begin
          nxt_prdata = {30'h00000000, irqMask_ff};
        end
        `OFF_CAPTURE: begin
          nxt_prdata = {15'h0000, capturedCount_ff};
        end
        default: begin
          nxt_prdata = 32'h00000000;
        end
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions and covers.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_edge_capture: assert property (
    rise && state_ff != ST_IDLE && !startReq |=> captureDoneEvent)
    else $error("Valid edge did not raise capture done.");
  chk_counter_clear: assert property (
    captureDoneEvent && !$past(startReq) |-> intervalCounter_ff == `CNT_ZERO)
    else $error("Counter not cleared after capture.");
  chk_counter_step: assert property (
    cntEn && state_ff != ST_IDLE && !rise && !startReq
    |=> intervalCounter_ff == $past(intervalCounter_ff) + 16'h0001)
    else $error("Counter did not advance on count clock.");
  chk_prescale_gate: assert property (
    cntEn && countClockPrescaler_ff != 4'h0 && $past(countClockPrescaler_ff, BASE_DIV) != 4'h0
    |-> !$past(cntEn, BASE_DIV))
    else $error("Count enable on two base ticks in a row.");
  chk_ovf_wrap: assert property (
    cntEn && state_ff != ST_IDLE && !rise && !startReq
    && intervalCounter_ff == `CNT_MAX |=> overflowStatus_ff && intervalCounter_ff == `CNT_ZERO)
    else $error("Wrap did not set overflow status.");
  chk_ovf_zero: assert property (
    storeEn && !extMode_ff && overflowStatus_ff && !startReq |=> capturedCount_ff == 17'h00000)
    else $error("Overflowed default result not zero.");
  chk_ext_status: assert property (
    storeEn && extMode_ff && !startReq
    |=> capturedCount_ff[16] == $past(overflowStatus_ff)
    && buffer_ff[{~$past(resultCount_ff), 1'b1}] == {15'h0000, $past(overflowStatus_ff)})
    else $error("Extended entry lacks overflow status.");
  chk_first_drop: assert property (
    state_ff == ST_ARMED && !startReq |=> resultCount_ff == 3'h0)
    else $error("First capture was stored.");
  chk_fill_order: assert property (
    storeEn && !extMode_ff && !startReq
    |=> buffer_ff[{1'b0, ~$past(resultCount_ff)}] == $past(resultLo))
    else $error("Result not stored at the top-down slot.");
  chk_stop_eight: assert property (
    storeEn && resultCount_ff == `LAST_SLOT && !startReq
    |=> state_ff == ST_IDLE && measurementComplete ##1 !captureDoneEvent)
    else $error("No idle stop after eight results.");

  cov_first_store: cover property (state_ff == ST_MEASURE && storeEn);
  cov_complete: cover property ($rose(measurementComplete));
  cov_ext_ovf: cover property (storeEn && extMode_ff && overflowStatus_ff);
endmodule : pulse_interval_capture

// ===== pulse_interval_capture_bench.sv
/*
  Self-checking bench of the pulse interval capture block: APB master
  tasks, a queue of expected read results with a watcher, a pulse source.
  Assumes zero or more wait states on APB and one event per capture.
*/
`timescale 1ns/100ps
`include "pic_consts.svh"
module pulse_interval_capture_bench
  import pic_pkg::*;
  ;
  // ----------------------------------------------------------------------
  // Signals and bookkeeping.
  // ----------------------------------------------------------------------
  typedef struct {logic [31:0] exp; int tol; int sh; logic [31:0] msk; logic err;} note_s;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, got, seed;
  logic pulseInputPin, captureDoneEvent, measurementComplete, irq;
  note_s notes[$]; // Expected read results, oldest first.
  note_s cur;
  int badCount, cmpCount, evCount, d;

  // Clock of 8 ns.
  always #4 sys_clk = ~sys_clk;

  pulse_interval_capture i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulseInputPin(pulseInputPin),
    .captureDoneEvent(captureDoneEvent), .measurementComplete(measurementComplete),
    .irq(irq));
  pic_pulse_source i_src (.sys_clk(sys_clk), .pulseInputPin(pulseInputPin));

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  // Xorshift generator; the seed is fixed so every run is the same.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic fail(input string m);
    badCount++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail

  task automatic chk(input logic gotBit, input logic expBit, input string m);
    cmpCount++;
    if (gotBit !== expBit) fail(m);
  endtask : chk

  // One APB transfer; the request holds until pready is seen high.
  task automatic apbXfer(input logic [11:0] a, input logic w, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= v;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge sys_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle cycle keeps two transfers from touching psel in one step.
    @(posedge sys_clk);
  endtask : apbXfer

  // A read notes its expectation first; the watcher judges the answer.
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input int tol, input int sh,
                    input logic [31:0] m, input logic err);
    notes.push_back(note_s'{e, tol, sh, m, err});
    apbXfer(a, 1'b0, 32'h0000_0000);
  endtask : rd

  // ----------------------------------------------------------------------
  // Watcher: counts capture events and judges every completed read.
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (captureDoneEvent === 1'b1) evCount++;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (notes.size() == 0) begin
        fail("read without a noted expectation");
      end else begin
        cur = notes.pop_front();
        got = (prdata >> cur.sh) & cur.msk;
        cmpCount++;
        // Interval results carry one count of quantisation, hence the tolerance.
        d = int'(got) - int'(cur.exp);
        if ($isunknown(got) || pslverr !== cur.err || d > cur.tol || d < -cur.tol) begin
          fail($sformatf("addr %h read %h expected %h", paddr, got, cur.exp));
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // One full measurement: start, ten rising edges, then the results.
  // ----------------------------------------------------------------------
  task automatic measure(input logic ext, input int psc);
    int g[10];
    int dv;
    int base;
    dv = `BASE_DIV << psc;
    apbXfer(`OFF_CTRL, 1'b1, {26'h0, 4'(psc), ext, 1'b1});
    rd(`OFF_CTRL, {26'h0, 4'(psc), ext, 1'b0}, 0, 0, 32'hffff_ffff, 1'b0);
    base = evCount;
    for (int k = 0; k < 10; k++) begin
      // At least six count clocks apart, well above two count clocks.
      g[k] = 6 + int'(rnd() % 32'h0000005f);
      i_src.pulse(g[k] * dv);
    end
    // The tenth edge comes after completion and must be ignored.
    chk(evCount - base == 9, 1'b1, "capture event count");
    chk(measurementComplete, 1'b1, "complete flag");
    rd(`OFF_STATUS, 32'h0000_0002, 0, 0, 32'h0000_0077, 1'b0);
    rd(`OFF_CAPTURE, g[7], 1, 0, 32'h0001_ffff, 1'b0);
    for (int n = 0; n < 8; n++) begin
      if (ext) begin
        rd(`OFF_BUFFER + 12'(4 * (7 - n)), g[n], 1, 0, 32'hffff_ffff, 1'b0);
      end else begin
        rd(`OFF_BUFFER + 12'(4 * ((7 - n) / 2)), g[n], 1, 16 * ((7 - n) % 2), 32'h0000_ffff,
           1'b0);
      end
    end
  endtask : measure

  // ----------------------------------------------------------------------
  // Verdict.
  // ----------------------------------------------------------------------
  task automatic tallyAndFinish();
    $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tallyAndFinish

  // Watchdog, beyond the at most 65000 cycles the sequence needs, and below
  // the run budget of the bench.
  initial begin
    repeat (90000) @(posedge sys_clk);
    fail("watchdog expired");
    tallyAndFinish();
  end

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    seed = 32'h0000cbcd;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    // Reset values and an unmapped address.
    rd(`OFF_CTRL, 32'h0, 0, 0, 32'hffff_ffff, 1'b0);
    rd(`OFF_STATUS, 32'h0, 0, 0, 32'hffff_ffff, 1'b0);
    rd(`OFF_IRQ_MASK, 32'h0, 0, 0, 32'hffff_ffff, 1'b0);
    rd(12'h014, 32'h0, 0, 0, 32'hffff_ffff, 1'b1);
    // An edge before start must not capture anything.
    i_src.pulse(200);
    chk(evCount == 0, 1'b1, "capture while idle");
    measure(1'b0, 0);
    // Interrupt: both events pending, masked, unmasked, cleared.
    rd(`OFF_IRQ_STAT, 32'h3, 0, 0, 32'h3, 1'b0);
    chk(irq, 1'b0, "irq while masked");
    apbXfer(`OFF_IRQ_MASK, 1'b1, 32'h0000_0002);
    rd(`OFF_IRQ_MASK, 32'h2, 0, 0, 32'h3, 1'b0);
    chk(irq, 1'b1, "irq for completion");
    apbXfer(`OFF_IRQ_STAT, 1'b1, 32'h0000_0002);
    chk(irq, 1'b0, "irq after clear");
    rd(`OFF_IRQ_STAT, 32'h1, 0, 0, 32'h3, 1'b0);
    // Extended mode with the count clock halved.
    measure(1'b1, 1);
    repeat (3) @(posedge sys_clk);
    tallyAndFinish();
  end
endmodule : pulse_interval_capture_bench
